/* src/spc_top.sv */
`timescale 1ns/1ns
// ****************************************
// Status pin clock routing and channel 7 divider
// ****************************************
module spc_top (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       synth_a_edge,
  input  wire logic       synth_b_edge,
  input  wire logic       ch7_src_edge,
  input  wire logic       status_a_in,
  input  wire logic       status_b_in,
  output logic            ch7_clk,
  output logic            indicator_pin_a_out,
  output logic            indicator_pin_a_oe,
  output logic            indicator_pin_b_out,
  output logic            indicator_pin_b_oe
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] channel7_divider;
  logic [7:0] status_pin_clock_control;
  logic [7:0] se_div_a_value;
  logic [7:0] se_div_b_value;

  // Divider value decode: 0 off, 1..5 give 6, else n+1
  function automatic logic [7:0] se_ratio_m1(input logic [7:0] v);
    se_ratio_m1 = (v <= spc_pkg::SE_MIN_CODE) ? spc_pkg::SE_MIN_M1 : v;
  endfunction : se_ratio_m1

  // Pre-divider decode, reserved code counts as off
  function automatic logic pre_on(input logic [1:0] s);
    pre_on = (s == spc_pkg::PRE_DIV4) || (s == spc_pkg::PRE_DIV5);
  endfunction : pre_on

  function automatic logic [7:0] pre_m1(input logic [1:0] s);
    pre_m1 = (s == spc_pkg::PRE_DIV5) ? spc_pkg::PRE_DIV5_M1 : spc_pkg::PRE_DIV4_M1;
  endfunction : pre_m1

  // Field views
  logic [1:0] synth_b_single_ended_prediv_select;
  logic [1:0] synth_a_single_ended_prediv_select;
  logic [1:0] pin_b_source_select;
  logic [1:0] pin_a_source_select;
  assign synth_b_single_ended_prediv_select = status_pin_clock_control[spc_pkg::PRE_B_LSB +: 2];
  assign synth_a_single_ended_prediv_select = status_pin_clock_control[spc_pkg::PRE_A_LSB +: 2];
  assign pin_b_source_select                = status_pin_clock_control[spc_pkg::PIN_B_LSB +: 2];
  assign pin_a_source_select                = status_pin_clock_control[spc_pkg::PIN_A_LSB +: 2];

  // Write decode
  logic wr_ch7;
  logic wr_ctrl;
  logic wr_se_a;
  logic wr_se_b;
  assign wr_ch7  = wr && (addr == spc_pkg::ADDR_CH7_DIV);
  assign wr_ctrl = wr && (addr == spc_pkg::ADDR_PIN_CTRL);
  assign wr_se_a = wr && (addr == spc_pkg::ADDR_SE_DIV_A);
  assign wr_se_b = wr && (addr == spc_pkg::ADDR_SE_DIV_B);

  // Register writes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      channel7_divider         <= spc_pkg::RST_CH7_DIV;
      status_pin_clock_control <= spc_pkg::RST_PIN_CTRL;
      se_div_a_value           <= spc_pkg::RST_SE_DIV;
      se_div_b_value           <= spc_pkg::RST_SE_DIV;
    end else begin
      if (wr_ch7)  channel7_divider         <= wdata;
      if (wr_ctrl) status_pin_clock_control <= wdata;
      if (wr_se_a) se_div_a_value           <= wdata;
      if (wr_se_b) se_div_b_value           <= wdata;
    end
  end

  // ****************************************
  // Dividers
  // ****************************************
  logic pre_a_tick;
  logic pre_b_tick;
  logic div_a_tick;
  logic div_b_tick;
  logic div_a_clk;
  logic div_b_clk;
  logic ch7_tick;
  logic pre_a_on;
  logic pre_b_on;
  logic div_a_on;
  logic div_b_on;
  assign pre_a_on = pre_on(synth_a_single_ended_prediv_select);
  assign pre_b_on = pre_on(synth_b_single_ended_prediv_select);
  assign div_a_on = pre_a_on && (se_div_a_value != 8'h00);
  assign div_b_on = pre_b_on && (se_div_b_value != 8'h00);

  // Channel 7 divides its source by field plus one
  spc_div u_ch7 (
    .clock    (clock),
    .rst_n    (rst_n),
    .en_in    (ch7_src_edge),
    .enable   (1'b1),
    .ratio_m1 (channel7_divider),
    .tick     (ch7_tick),
    .clk_out  (ch7_clk)
  );

  spc_div u_pre_a (
    .clock    (clock),
    .rst_n    (rst_n),
    .en_in    (synth_a_edge),
    .enable   (pre_a_on),
    .ratio_m1 (pre_m1(synth_a_single_ended_prediv_select)),
    .tick     (pre_a_tick),
    .clk_out  ()
  );

  spc_div u_pre_b (
    .clock    (clock),
    .rst_n    (rst_n),
    .en_in    (synth_b_edge),
    .enable   (pre_b_on),
    .ratio_m1 (pre_m1(synth_b_single_ended_prediv_select)),
    .tick     (pre_b_tick),
    .clk_out  ()
  );

  // Divider A from synth A pre-divider, B from synth B
  spc_div u_div_a (
    .clock    (clock),
    .rst_n    (rst_n),
    .en_in    (pre_a_tick),
    .enable   (div_a_on),
    .ratio_m1 (se_ratio_m1(se_div_a_value)),
    .tick     (div_a_tick),
    .clk_out  (div_a_clk)
  );

  spc_div u_div_b (
    .clock    (clock),
    .rst_n    (rst_n),
    .en_in    (pre_b_tick),
    .enable   (div_b_on),
    .ratio_m1 (se_ratio_m1(se_div_b_value)),
    .tick     (div_b_tick),
    .clk_out  (div_b_clk)
  );

  // ****************************************
  // Status pin muxes
  // ****************************************
  logic next_pin_a;
  logic next_pin_b;
  assign next_pin_a = (pin_a_source_select == spc_pkg::PIN_DIV_A)  ? div_a_clk :
                      (pin_a_source_select == spc_pkg::PIN_DIV_B)  ? div_b_clk :
                      (pin_a_source_select == spc_pkg::PIN_STATUS) ? status_a_in : 1'b0;
  assign next_pin_b = (pin_b_source_select == spc_pkg::PIN_DIV_A)  ? div_a_clk :
                      (pin_b_source_select == spc_pkg::PIN_DIV_B)  ? div_b_clk :
                      (pin_b_source_select == spc_pkg::PIN_STATUS) ? status_b_in : 1'b0;

  // Pin drivers, disabled code releases the pin
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      indicator_pin_a_out <= 1'b0;
      indicator_pin_b_out <= 1'b0;
      indicator_pin_a_oe  <= 1'b0;
      indicator_pin_b_oe  <= 1'b0;
    end else begin
      indicator_pin_a_out <= next_pin_a;
      indicator_pin_b_out <= next_pin_b;
      indicator_pin_a_oe  <= (pin_a_source_select != spc_pkg::PIN_OFF);
      indicator_pin_b_oe  <= (pin_b_source_select != spc_pkg::PIN_OFF);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  logic [7:0] state_view;
  logic [7:0] next_rdata;
  assign state_view = {indicator_pin_b_oe, indicator_pin_a_oe, div_b_clk, div_a_clk,
                       pre_b_on, pre_a_on, 1'b0, ch7_clk};
  assign next_rdata = (addr == spc_pkg::ADDR_CH7_DIV)  ? channel7_divider :
                      (addr == spc_pkg::ADDR_PIN_CTRL) ? status_pin_clock_control :
                      (addr == spc_pkg::ADDR_SE_DIV_A) ? se_div_a_value :
                      (addr == spc_pkg::ADDR_SE_DIV_B) ? se_div_b_value :
                      (addr == spc_pkg::ADDR_STATE)    ? state_view : 8'h00;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Source edges since the last channel 7 edge
  logic [8:0] ch7_since;
  logic       ch7_valid;
  always_ff @(posedge clock) begin
    if (!rst_n || wr_ch7) begin
      ch7_since <= 9'h000;
      ch7_valid <= 1'b0;
    end else if (ch7_tick) begin
      ch7_since <= 9'h000;
      ch7_valid <= 1'b1;
    end else if (ch7_src_edge) begin
      ch7_since <= ch7_since + 9'h001;
    end
  end

  a_ch7_ratio: assert property ((ch7_tick && ch7_valid) |-> (ch7_since == {1'b0, channel7_divider}))
    else $error("channel 7 edge spacing wrong");
  a_pre_b_quiet: assert property (!pre_on(synth_b_single_ended_prediv_select) |-> !pre_b_tick ##1 !div_b_clk)
    else $error("synth b pre-divider or divider b runs while off");
  a_pre_a_quiet: assert property (!pre_on(synth_a_single_ended_prediv_select) |-> !pre_a_tick ##1 !div_a_clk)
    else $error("synth a pre-divider or divider a runs while off");
  a_div_a_source: assert property (div_a_tick |-> pre_a_tick)
    else $error("divider a edge without synth a pre-divider edge");
  a_div_b_source: assert property (div_b_tick |-> pre_b_tick)
    else $error("divider b edge without synth b pre-divider edge");
  a_pin_a_status: assert property ((pin_a_source_select == spc_pkg::PIN_STATUS) |=>
    (indicator_pin_a_out == $past(status_a_in)) && indicator_pin_a_oe)
    else $error("pin a does not follow status");
  a_pin_b_off: assert property ((pin_b_source_select == spc_pkg::PIN_OFF) |=> !indicator_pin_b_oe)
    else $error("pin b driven while disabled");
  a_pin_b_div: assert property ((pin_b_source_select == spc_pkg::PIN_DIV_B) |=>
    (indicator_pin_b_out == $past(div_b_clk)))
    else $error("pin b does not follow divider b");
  // Three cycles: divider clears, then the pin flop follows it
  a_pin_silent: assert property ((!pre_a_on && pin_a_source_select == spc_pkg::PIN_DIV_A) [*3] |->
    !indicator_pin_a_out)
    else $error("pin a toggles from a stopped divider");

endmodule : spc_top

/* src/spc_pkg.sv */
// Notes on behaviour
// - Channel 7 divides by field plus one
// - Each pin may use either divider
// - Each divider fed from its own synth pre-divider only
// - Synth B pre-divider: off, /4, /5
// - Synth A pre-divider: off, /4, /5
// - Pin B select: div A, B, status, off
// - Pin A select: div A, B, status, off
// - Divider A divides synth A pre-divider
// - Divider B divides synth B pre-divider
package spc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CH7_DIV   = 8'h2c;
  localparam logic [7:0] ADDR_PIN_CTRL  = 8'h2d;
  localparam logic [7:0] ADDR_SE_DIV_A  = 8'h2e;
  localparam logic [7:0] ADDR_SE_DIV_B  = 8'h2f;
  localparam logic [7:0] ADDR_STATE     = 8'h30;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_CH7_DIV    = 8'h05;
  localparam logic [7:0] RST_PIN_CTRL   = 8'h0a;
  localparam logic [7:0] RST_SE_DIV     = 8'h00;

  // ****************************************
  // Field positions in the pin control register
  // ****************************************
  localparam int PRE_B_LSB = 6;
  localparam int PRE_A_LSB = 4;
  localparam int PIN_B_LSB = 2;
  localparam int PIN_A_LSB = 0;

  // ****************************************
  // Codes
  // ****************************************
  localparam logic [1:0] PRE_OFF        = 2'h0;
  localparam logic [1:0] PRE_DIV4       = 2'h1;
  localparam logic [1:0] PRE_DIV5       = 2'h2;
  localparam logic [7:0] PRE_DIV4_M1    = 8'h03;
  localparam logic [7:0] PRE_DIV5_M1    = 8'h04;
  localparam logic [1:0] PIN_DIV_A      = 2'h0;
  localparam logic [1:0] PIN_DIV_B      = 2'h1;
  localparam logic [1:0] PIN_STATUS     = 2'h2;
  localparam logic [1:0] PIN_OFF        = 2'h3;
  localparam logic [7:0] SE_MIN_CODE    = 8'h05;
  localparam logic [7:0] SE_MIN_M1      = 8'h05;

endpackage : spc_pkg

/* src/spc_div.sv */
`timescale 1ns/1ns
// ****************************************
// Edge divider: one output edge per ratio input edges
// ****************************************
module spc_div (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       en_in,
  input  wire logic       enable,
  input  wire logic [7:0] ratio_m1,
  output logic            tick,
  output logic            clk_out
);

  logic [7:0] count;
  logic       wrap;

  // Wrap also when the ratio shrinks below the count
  assign wrap = (count >= ratio_m1);
  assign tick = enable & en_in & wrap;

  // Count input edges, toggle the level on every output edge
  always_ff @(posedge clock) begin
    if (!rst_n || !enable) begin
      count   <= 8'h00;
      clk_out <= 1'b0;
    end else if (en_in) begin
      count <= wrap ? 8'h00 : count + 8'h01;
      if (wrap) begin
        clk_out <= ~clk_out;
      end
    end
  end

endmodule : spc_div

/* verification/testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic       clock;
  logic       rst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       synth_a_edge;
  logic       synth_b_edge;
  logic       ch7_src_edge;
  logic       status_a_in;
  logic       status_b_in;
  logic       ch7_clk;
  logic       pin_a_out;
  logic       pin_a_oe;
  logic       pin_b_out;
  logic       pin_b_oe;
  int         err_count;
  int         cmp_count;
  int         cycles;
  int         tog_ch7;
  int         tog_a;
  int         tog_b;
  logic [2:0] last_lvl;

  spc_top u_dut (
    .clock               (clock),
    .rst_n               (rst_n),
    .addr                (addr),
    .wdata               (wdata),
    .wr                  (wr),
    .rd                  (rd),
    .rdata               (rdata),
    .synth_a_edge        (synth_a_edge),
    .synth_b_edge        (synth_b_edge),
    .ch7_src_edge        (ch7_src_edge),
    .status_a_in         (status_a_in),
    .status_b_in         (status_b_in),
    .ch7_clk             (ch7_clk),
    .indicator_pin_a_out (pin_a_out),
    .indicator_pin_a_oe  (pin_a_oe),
    .indicator_pin_b_out (pin_b_out),
    .indicator_pin_b_oe  (pin_b_oe)
  );

  // ****************************************
  // Clock, timeout and toggle counters
  // ****************************************
  initial clock = 1'b0;
  always #4 clock = ~clock;

  // Cut a hang short
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      close_out();
    end
  end

  // Count level changes of the divided outputs
  always @(posedge clock) begin
    if (ch7_clk !== last_lvl[0]) tog_ch7 = tog_ch7 + 1;
    if (pin_a_out !== last_lvl[1]) tog_a = tog_a + 1;
    if (pin_b_out !== last_lvl[2]) tog_b = tog_b + 1;
    last_lvl = {pin_b_out, pin_a_out, ch7_clk};
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  // Pulse edge inputs n times, then let outputs settle
  task automatic pulses(input int n, input logic ch7, input logic syn);
    @(posedge clock);
    tog_ch7 = 0;
    tog_a   = 0;
    tog_b   = 0;
    repeat (n) begin
      ch7_src_edge <= ch7;
      synth_a_edge <= syn;
      synth_b_edge <= syn;
      @(posedge clock);
    end
    ch7_src_edge <= 1'b0;
    synth_a_edge <= 1'b0;
    synth_b_edge <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : pulses

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin : main
    logic [7:0] d;
    {rst_n, addr, wdata, wr, rd} = '0;
    {synth_a_edge, synth_b_edge, ch7_src_edge} = '0;
    status_a_in = 1'b1;
    status_b_in = 1'b0;
    {err_count, cmp_count, cycles, tog_ch7, tog_a, tog_b} = '0;
    last_lvl = '0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values, status mode, unmapped place
    reg_rd(spc_pkg::ADDR_CH7_DIV, d); check(d, 8'h05);
    reg_rd(spc_pkg::ADDR_PIN_CTRL, d); check(d, 8'h0a);
    reg_rd(spc_pkg::ADDR_SE_DIV_A, d); check(d, 8'h00);
    reg_rd(spc_pkg::ADDR_SE_DIV_B, d); check(d, 8'h00);
    reg_wr(8'h31, 8'h5a);
    reg_rd(8'h31, d); check(d, 8'h00);
    check({6'h0, pin_b_oe, pin_a_oe}, 8'h03);
    check({6'h0, pin_b_out, pin_a_out}, 8'h01);
    $display("test reset done");
    // Channel 7 ratios 1, 3 and 256
    reg_wr(spc_pkg::ADDR_CH7_DIV, 8'h00);
    pulses(10, 1'b1, 1'b0); check(8'(tog_ch7), 8'd10);
    reg_wr(spc_pkg::ADDR_CH7_DIV, 8'h02);
    pulses(60, 1'b1, 1'b0); check(8'(tog_ch7), 8'd20);
    reg_wr(spc_pkg::ADDR_CH7_DIV, 8'hff);
    pulses(512, 1'b1, 1'b0); check(8'(tog_ch7), 8'd2);
    $display("test channel 7 done");
    // Pin A from divider A (/4 then /7), pin B from divider B (/5 then /6)
    reg_wr(spc_pkg::ADDR_SE_DIV_A, 8'h06);
    reg_wr(spc_pkg::ADDR_SE_DIV_B, 8'h01);
    reg_wr(spc_pkg::ADDR_PIN_CTRL, 8'h94);
    reg_rd(spc_pkg::ADDR_PIN_CTRL, d); check(d, 8'h94);
    pulses(420, 1'b0, 1'b1);
    check(8'(tog_a), 8'd15);
    check(8'(tog_b), 8'd14);
    check({6'h0, pin_b_oe, pin_a_oe}, 8'h03);
    // Pins swapped, pre-dividers swapped
    reg_wr(spc_pkg::ADDR_PIN_CTRL, 8'h61);
    repeat (3) @(posedge clock);
    pulses(840, 1'b0, 1'b1);
    check(8'(tog_a), 8'd35);
    check(8'(tog_b), 8'd24);
    $display("test routing done");
    // Pre-dividers off and reserved: pins stay quiet
    reg_wr(spc_pkg::ADDR_PIN_CTRL, 8'hc4);
    repeat (3) @(posedge clock);
    pulses(100, 1'b0, 1'b1);
    check(8'(tog_a + tog_b), 8'd0);
    check({6'h0, pin_b_out, pin_a_out}, 8'h00);
    // Pins disabled, then back to status levels
    reg_wr(spc_pkg::ADDR_PIN_CTRL, 8'h0f);
    repeat (2) @(posedge clock);
    #1;
    check({4'h0, pin_b_oe, pin_a_oe, pin_b_out, pin_a_out}, 8'h00);
    @(posedge clock);
    status_a_in <= 1'b0;
    status_b_in <= 1'b1;
    reg_wr(spc_pkg::ADDR_PIN_CTRL, 8'h0a);
    repeat (2) @(posedge clock);
    #1;
    check({4'h0, pin_b_oe, pin_a_oe, pin_b_out, pin_a_out}, 8'h0e);
    // State view: both pins driven, dividers and pre-dividers stopped
    reg_rd(spc_pkg::ADDR_STATE, d); check(d, 8'hc0);
    $display("test disable done");
    close_out();
  end : main
endmodule : testbench
